/* File: dv/cch_ctl_model.sv */
// cch_ctl_model: remote controller that sends command lines and reads replies.
// assumes the handler's byte, hold-off and response ports on the same clock.
module cch_ctl_model (
  input  wire logic       mclk_in,
  input  wire logic       hold_off_in,
  input  wire logic       rsp_vld_in,
  input  wire logic [7:0] rsp_byte_in,
  output logic            byte_vld_out,
  output logic [7:0]      byte_out,
  output logic            rsp_rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rsp_q[$];
  int         lag = 0;
  initial begin
    byte_vld_out = 1'b0;
    byte_out     = 8'h00;
    rsp_rd_out   = 1'b0;
  end
  task automatic send_line(input string s, output bit ok);
    int i;
    int n;
    ok = 1'b1;
    for (i = 0; i < s.len(); i++) begin
      byte_vld_out <= 1'b1;
      byte_out     <= s[i];
      // byte stands until an edge that sees hold-off low takes it
      n = 0;
      do begin
        @(posedge mclk_in);
        n++;
      end while (hold_off_in && n < 400);
      if (hold_off_in) ok = 1'b0;
      // released line shows the inverse, not a stale byte
      byte_vld_out <= 1'b0;
      byte_out     <= ~s[i];
      @(posedge mclk_in);
    end
  endtask
  task automatic get_rsp(output bit ok);
    int n;
    logic [7:0] b;
    rsp_q.delete();
    ok = 1'b0;
    for (n = 0; n < 400 && !ok; n++) begin
      @(posedge mclk_in);
      if (rsp_vld_in && !rsp_rd_out) begin
        repeat (lag) @(posedge mclk_in);
        b = rsp_byte_in;
        rsp_q.push_back(b);
        rsp_rd_out <= 1'b1;
        ok = (b === cch_pkg::CH_NL);
      end else begin
        rsp_rd_out <= 1'b0;
      end
    end
    @(posedge mclk_in);
    rsp_rd_out <= 1'b0;
  endtask
endmodule // cch_ctl_model

/* File: dv/cch_top_test.sv */
// cch_top_test: self-checking bench for the common command handler.
// assumes cch_ctl_model as the controller; registers are driven from here.
module cch_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h41;  // arbitrary value, rom default
  localparam logic [7:0] MODEL = 8'h42;  // arbitrary value, rom default
  logic       mclk_in      = 1'b0;
  logic       rstn_in      = 1'b0;
  logic       busy_in      = 1'b0;
  logic       poll_in      = 1'b0;
  logic [3:0] reg_addr_in  = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_wr_in    = 1'b0;
  logic       reg_rd_in    = 1'b0;
  logic       byte_vld_in;
  logic [7:0] byte_in;
  logic       rsp_rd_in;
  logic [7:0] reg_rdata_out;
  logic       rsp_vld_out;
  logic [7:0] rsp_byte_out;
  logic       hold_off_out;
  logic       trig_out;
  logic       dflt_out;
  logic [7:0] stb_out;
  logic       irq_out;
  int         n_mismatch   = 0;
  int         n_checks     = 0;
  int         seed         = 9;

  always #20 mclk_in = ~mclk_in;

  cch_top cch_top_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .byte_vld_in(byte_vld_in),
    .byte_in(byte_in), .busy_in(busy_in), .rsp_rd_in(rsp_rd_in), .poll_in(poll_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rsp_vld_out(rsp_vld_out),
    .rsp_byte_out(rsp_byte_out), .hold_off_out(hold_off_out), .trig_out(trig_out),
    .dflt_out(dflt_out), .stb_out(stb_out), .irq_out(irq_out));
  cch_ctl_model cch_ctl_model_i (.mclk_in(mclk_in), .hold_off_in(hold_off_out),
    .rsp_vld_in(rsp_vld_out), .rsp_byte_in(rsp_byte_out), .byte_vld_out(byte_vld_in),
    .byte_out(byte_in), .rsp_rd_out(rsp_rd_in));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in    <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic reg_chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in   <= 1'b0;
    @(posedge mclk_in);
    d = reg_rdata_out;
    chk(d, e);
  endtask
  task automatic cmd(input string s);
    bit ok;
    cch_ctl_model_i.send_line(s, ok);
    if (!ok) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic rsp_chk(input string e);
    bit ok;
    cch_ctl_model_i.get_rsp(ok);
    chk(8'(ok), 8'h01);
    if (!ok) final_report();
    chk(8'(cch_ctl_model_i.rsp_q.size()), 8'(e.len()));
    foreach (cch_ctl_model_i.rsp_q[i])
      if (i < e.len()) chk(cch_ctl_model_i.rsp_q[i], e[i]);
  endtask
  task automatic watch(input int n, output int trg, output int dfl);
    trg = 0;
    dfl = 0;
    repeat (n) begin
      @(posedge mclk_in);
      trg += int'(trig_out === 1'b1);
      dfl += int'(dflt_out === 1'b1);
    end
  endtask

  initial begin
    logic [7:0] s0;
    int         trg;
    int         dfl;
    int         m;
    repeat (10) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in);
    chk(stb_out, 8'h00);
    reg_chk(cch_pkg::ADR_CFG, cch_pkg::CFG_RESET);
    reg_chk(cch_pkg::ADR_OPT, {6'h00, cch_pkg::OPT_RESET});
    reg_chk(4'hF, 8'h00);
    reg_wr(cch_pkg::ADR_IRQ_EN, 8'h0F);
    cch_ctl_model_i.lag = $random(seed) & 3;
    cmd("*ID\rN?\n");
    rsp_chk($sformatf("%c,%c,0,0\n", MAKER, MODEL));
    cmd("*opt?\n");
    rsp_chk("1\n");
    reg_wr(cch_pkg::ADR_OPT, 8'h02);
    cmd("*OPT?\r\n");
    rsp_chk("2\n");
    // every run mode with and without the bus source
    for (m = 0; m < 8; m++) begin
      reg_wr(cch_pkg::ADR_CFG, {5'h00, m[2:0]});
      cmd("*TRG\n");
      watch(8, trg, dfl);
      chk(8'(trg), ((m[1:0] == cch_pkg::RUN_TRIG || m[1:0] == cch_pkg::RUN_BURST)
                    && m[2]) ? 8'h01 : 8'h00);
    end
    chk({7'h00, irq_out}, 8'h01);
    reg_wr(cch_pkg::ADR_IRQ_EN, 8'h00);
    @(posedge mclk_in);
    chk({7'h00, irq_out}, 8'h00);
    reg_wr(cch_pkg::ADR_IRQ_CL, 8'h0F);
    reg_chk(cch_pkg::ADR_IRQ_ST, 8'h00);
    reg_wr(cch_pkg::ADR_IRQ_EN, 8'h0F);
    s0 = 8'($random(seed)) | 8'h01;
    reg_wr(cch_pkg::ADR_CFG, s0 & 8'h07);
    cmd("*RST\n");
    watch(8, trg, dfl);
    chk(8'(dfl), 8'h01);
    reg_chk(cch_pkg::ADR_CFG, cch_pkg::CFG_RESET);
    // malformed command leaves settings alone
    s0 = 8'($random(seed)) & 8'h07;
    reg_wr(cch_pkg::ADR_CFG, s0);
    cmd($sformatf("*Q%c\n", 8'h30 + (8'($random(seed)) & 8'h07)));
    watch(6, trg, dfl);
    chk(8'(trg + dfl), 8'h00);
    reg_chk(cch_pkg::ADR_CFG, s0);
    reg_chk(cch_pkg::ADR_ERRCNT, 8'h01);
    reg_chk(cch_pkg::ADR_ESR, 8'h01 << cch_pkg::ESR_CME);
    reg_chk(cch_pkg::ADR_IRQ_ST, (8'h01 << cch_pkg::IRQ_ERR) | (8'h01 << cch_pkg::IRQ_RST));
    chk({7'h00, irq_out}, 8'h01);
    poll_in <= 1'b1;
    @(posedge mclk_in);
    poll_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    s0 = (8'h01 << cch_pkg::STB_ESB) | (8'h01 << cch_pkg::STB_RQS);
    chk(stb_out, s0);
    cmd("*STB?\n");
    rsp_chk(string'({s0, cch_pkg::CH_NL}));
    chk({7'h00, stb_out[cch_pkg::STB_RQS]}, {7'h00, s0[cch_pkg::STB_RQS]});
    cmd("*CLS\n");
    watch(4, trg, dfl);
    reg_chk(cch_pkg::ADR_ESR, 8'h00);
    chk(stb_out, 8'h00);
    // completion answer waits for earlier work
    busy_in <= 1'b1;
    cmd("*OPC?\n");
    repeat (4) @(posedge mclk_in);
    repeat (16) begin
      @(posedge mclk_in);
      chk({6'h00, rsp_vld_out, hold_off_out}, 8'h01);
    end
    busy_in <= 1'b0;
    cch_ctl_model_i.lag = 3;
    repeat (4) @(posedge mclk_in);
    chk({7'h00, stb_out[cch_pkg::STB_MAV]}, 8'h01);
    rsp_chk("1\n");
    watch(4, trg, dfl);
    chk({7'h00, hold_off_out}, 8'h00);
    final_report();
  end
endmodule // cch_top_test

/* File: rtl/cch_decode.sv */
// cch_decode: collects one command line and names the common command in it.
// assumes bytes arrive one per cycle with a valid pulse; newline ends a line.
module cch_decode (
  input  wire logic              mclk_in,
  input  wire logic              rstn_in,
  input  wire logic              byte_vld_in,
  input  wire logic [7:0]        byte_in,
  output cch_pkg::cch_cmd_t      cmd_out,
  output logic                   cmd_vld_out
);
  logic [7:0]                    buf_reg [cch_pkg::LINE_LEN];
  logic [cch_pkg::IDX_W:0]       len_reg;
  logic [7:0]                    up;
  cch_pkg::cch_cmd_t             cmd_next;

  // upper-case fold so lower-case commands match too
  always_comb begin
    up = byte_in;
    if (byte_in >= 8'h61 && byte_in <= 8'h7A) begin
      up = byte_in - cch_pkg::CH_CASE;
    end
  end

  function automatic logic m3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                              input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    m3 = (a == x) && (b == y) && (c == z);
  endfunction

  always_comb begin
    cmd_next = cch_pkg::CCH_CMD_BAD;
    if (len_reg == 4'h4 && buf_reg[0] == cch_pkg::CH_STAR) begin
      if (m3(buf_reg[1], buf_reg[2], buf_reg[3], 8'h52, 8'h53, 8'h54)) cmd_next = cch_pkg::CCH_CMD_RST;
      if (m3(buf_reg[1], buf_reg[2], buf_reg[3], 8'h54, 8'h52, 8'h47)) cmd_next = cch_pkg::CCH_CMD_TRG;
      if (m3(buf_reg[1], buf_reg[2], buf_reg[3], 8'h43, 8'h4C, 8'h53)) cmd_next = cch_pkg::CCH_CMD_CLS;
    end else if (len_reg == 4'h5 && buf_reg[0] == cch_pkg::CH_STAR &&
                 buf_reg[4] == cch_pkg::CH_QM) begin
      if (m3(buf_reg[1], buf_reg[2], buf_reg[3], 8'h4F, 8'h50, 8'h43)) cmd_next = cch_pkg::CCH_CMD_OPC;
      if (m3(buf_reg[1], buf_reg[2], buf_reg[3], 8'h53, 8'h54, 8'h42)) cmd_next = cch_pkg::CCH_CMD_STB;
      if (m3(buf_reg[1], buf_reg[2], buf_reg[3], 8'h49, 8'h44, 8'h4E)) cmd_next = cch_pkg::CCH_CMD_IDN;
      if (m3(buf_reg[1], buf_reg[2], buf_reg[3], 8'h4F, 8'h50, 8'h54)) cmd_next = cch_pkg::CCH_CMD_OPT;
    end else if (len_reg == 4'h0) begin
      cmd_next = cch_pkg::CCH_CMD_NONE;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      len_reg     <= '0;
      cmd_out     <= cch_pkg::CCH_CMD_NONE;
      cmd_vld_out <= 1'b0;
      for (int i = 0; i < cch_pkg::LINE_LEN; i++) begin
        buf_reg[i] <= 8'h00;
      end
    end else begin
      cmd_vld_out <= 1'b0;
      if (byte_vld_in) begin
        if (byte_in == cch_pkg::CH_CR) begin
          len_reg <= len_reg;
        end else if (byte_in == cch_pkg::CH_NL) begin
          cmd_out     <= cmd_next;
          cmd_vld_out <= (cmd_next != cch_pkg::CCH_CMD_NONE);
          len_reg     <= '0;
        end else if (len_reg < 4'(cch_pkg::LINE_LEN)) begin
          buf_reg[len_reg[cch_pkg::IDX_W-1:0]] <= up;
          len_reg <= len_reg + 4'h1;
        end else begin
          // overlong lines stay marked as too long and decode as bad
          len_reg <= len_reg;
        end
      end
    end
  end
endmodule : cch_decode

/* File: rtl/cch_pkg.sv */
// cch_pkg: constants shared by the common command handler files.
// assumes an 8-bit ascii byte stream in and out, one clock (mclk_in).
package cch_pkg;
  localparam int          LINE_LEN   = 8;
  localparam int          IDX_W      = 3;
  localparam int          RSP_LEN    = 32;
  localparam int          RSP_W      = 5;
  localparam logic [7:0]  CH_NL      = 8'h0A;
  localparam logic [7:0]  CH_CR      = 8'h0D;
  localparam logic [7:0]  CH_STAR    = 8'h2A;
  localparam logic [7:0]  CH_QM      = 8'h3F;
  localparam logic [7:0]  CH_ZERO    = 8'h30;
  localparam logic [7:0]  CH_ONE     = 8'h31;
  localparam logic [7:0]  CH_TWO     = 8'h32;
  localparam logic [7:0]  CH_COMMA   = 8'h2C;
  localparam logic [7:0]  CH_CASE    = 8'h20;
  localparam logic [1:0]  RUN_CONT   = 2'h0;
  localparam logic [1:0]  RUN_TRIG   = 2'h1;
  localparam logic [1:0]  RUN_GATED  = 2'h2;
  localparam logic [1:0]  RUN_BURST  = 2'h3;
  localparam int          STB_MAV    = 4;
  localparam int          STB_ESB    = 5;
  localparam int          STB_RQS    = 6;
  localparam int          ESR_OPC    = 0;
  localparam int          ESR_CME    = 5;
  // interrupt status layout
  localparam int          IRQ_W      = 4;
  localparam int          IRQ_ERR    = 0;
  localparam int          IRQ_TRG    = 1;
  localparam int          IRQ_RST    = 2;
  localparam int          IRQ_RSP    = 3;
  localparam logic [3:0]  ADR_IRQ_ST = 4'h0;
  localparam logic [3:0]  ADR_IRQ_CL = 4'h1;
  localparam logic [3:0]  ADR_IRQ_EN = 4'h2;
  localparam logic [3:0]  ADR_CFG    = 4'h3;
  localparam logic [3:0]  ADR_STB    = 4'h4;
  localparam logic [3:0]  ADR_ESR    = 4'h5;
  localparam logic [3:0]  ADR_OPT    = 4'h6;
  localparam logic [3:0]  ADR_ERRCNT = 4'h7;
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [1:0]  OPT_RESET  = 2'h1;
  typedef enum logic [3:0] {
    CCH_CMD_NONE = 4'h0,
    CCH_CMD_RST  = 4'h1,
    CCH_CMD_TRG  = 4'h2,
    CCH_CMD_CLS  = 4'h3,
    CCH_CMD_OPC  = 4'h4,
    CCH_CMD_STB  = 4'h5,
    CCH_CMD_IDN  = 4'h6,
    CCH_CMD_OPT  = 4'h7,
    CCH_CMD_BAD  = 4'h8
  } cch_cmd_t;
endpackage : cch_pkg

/* File: rtl/cch_rsp_rom.sv */
// cch_rsp_rom: identity string storage with a registered read port.
// assumes the caller holds the address one cycle before using the data.
module cch_rsp_rom #(
  parameter logic [7:0] MAKER_CH = 8'h41,  // arbitrary value
  parameter logic [7:0] MODEL_CH = 8'h42   // arbitrary value
) (
  input  wire logic                    mclk_in,
  input  wire logic                    rstn_in,
  input  wire logic [cch_pkg::RSP_W-1:0] addr_in,
  output logic [7:0]                   data_out
);
  logic [7:0] rom [8];
  always_comb begin
    rom[0] = MAKER_CH;
    rom[1] = cch_pkg::CH_COMMA;
    rom[2] = MODEL_CH;
    rom[3] = cch_pkg::CH_COMMA;
    rom[4] = cch_pkg::CH_ZERO;
    rom[5] = cch_pkg::CH_COMMA;
    rom[6] = cch_pkg::CH_ZERO;
    rom[7] = cch_pkg::CH_NL;
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_out <= 8'h00;
    end else begin
      data_out <= rom[addr_in[2:0]];
    end
  end
endmodule : cch_rsp_rom

/* File: rtl/cch_top.sv */
// cch_top: common command handler with response sender and register port.
// assumes a byte source with valid pulses and a sink that pulls response bytes.
//
// Contract
// - reset command restores the default cfg setting; the option setting is kept
// - trigger acts only in trig/burst, bus source
// - clear status clears summary and events
// - opc query answers 1 after prior work
// - input held off until opc answer read
// - status query returns serial poll value
// - status query leaves bit 6 set
// - identity answer has four comma fields
// - fields hold maker, model, serial, options
// - missing identity fields answer ascii zero
// - option query answers 1 or 2
// - carriage returns are ignored
// - every response ends with newline
module cch_top (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        byte_vld_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        busy_in,
  input  wire logic        rsp_rd_in,
  input  wire logic        poll_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  output logic             rsp_vld_out,
  output logic [7:0]       rsp_byte_out,
  output logic             hold_off_out,
  output logic             trig_out,
  output logic             dflt_out,
  output logic [7:0]       stb_out,
  output logic             irq_out
);
  cch_pkg::cch_cmd_t          cmd;
  logic                       cmd_vld;
  logic [7:0]                 cfg_reg;
  logic [1:0]                 opt_reg;
  logic [7:0]                 esr_reg;
  logic [7:0]                 err_cnt_reg;
  logic                       rqs_reg;
  logic [cch_pkg::IRQ_W-1:0]  irq_st_reg;
  logic [cch_pkg::IRQ_W-1:0]  irq_en_reg;
  logic [cch_pkg::IRQ_W-1:0]  irq_ev;
  logic                       opc_pend_reg;
  logic [cch_pkg::RSP_W-1:0]  rsp_addr_reg;
  logic [cch_pkg::RSP_W-1:0]  rsp_addr_next;
  logic                       rsp_rom_reg;
  logic                       rsp_active_reg;
  logic [7:0]                 rsp_b0_reg;
  logic                       rsp_first_reg;
  logic [7:0]                 rom_data;
  logic [7:0]                 stb_val;
  logic                       cmd_in_vld;
  logic                       bus_trig;
  logic [1:0]                 run_mode;

  assign run_mode = cfg_reg[1:0];
  assign bus_trig = cfg_reg[2];
  // bytes wait while an answer is pending
  assign cmd_in_vld = byte_vld_in && !hold_off_out;

  cch_decode u_dec (
    .mclk_in     (mclk_in),
    .rstn_in     (rstn_in),
    .byte_vld_in (cmd_in_vld),
    .byte_in     (byte_in),
    .cmd_out     (cmd),
    .cmd_vld_out (cmd_vld)
  );

  // rom read data is registered, so it is addressed one step ahead of the sender
  always_comb begin
    rsp_addr_next = rsp_addr_reg;
    if (!rsp_active_reg && cmd_vld) begin
      rsp_addr_next = '0;
    end else if (rsp_active_reg && rsp_vld_out && rsp_rd_in) begin
      rsp_addr_next = rsp_addr_reg + 5'h01;
    end
  end

  cch_rsp_rom u_rom (
    .mclk_in  (mclk_in),
    .rstn_in  (rstn_in),
    .addr_in  (rsp_addr_next),
    .data_out (rom_data)
  );

  // same value a serial poll gives
  always_comb begin
    stb_val = 8'h00;
    stb_val[cch_pkg::STB_MAV] = rsp_active_reg;
    stb_val[cch_pkg::STB_ESB] = |esr_reg;
    stb_val[cch_pkg::STB_RQS] = rqs_reg;
  end

  // request-service latch; only a serial poll or clear drops it
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rqs_reg <= 1'b0;
    // clear status wins, its cause goes too
    end else if (cmd_vld && cmd == cch_pkg::CCH_CMD_CLS) begin
      rqs_reg <= 1'b0;
    end else if (|esr_reg) begin
      rqs_reg <= 1'b1;
    end else if (poll_in) begin
      rqs_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      esr_reg     <= 8'h00;
      err_cnt_reg <= 8'h00;
    end else if (cmd_vld) begin
      if (cmd == cch_pkg::CCH_CMD_CLS) begin
        esr_reg <= 8'h00;
      end else if (cmd == cch_pkg::CCH_CMD_BAD) begin
        esr_reg[cch_pkg::ESR_CME] <= 1'b1;
        err_cnt_reg <= err_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_reg  <= cch_pkg::CFG_RESET;
      opt_reg  <= cch_pkg::OPT_RESET;
      dflt_out <= 1'b0;
    end else begin
      dflt_out <= cmd_vld && cmd == cch_pkg::CCH_CMD_RST;
      if (cmd_vld && cmd == cch_pkg::CCH_CMD_RST) begin
        cfg_reg <= cch_pkg::CFG_RESET;
      end else if (reg_wr_in && reg_addr_in == cch_pkg::ADR_CFG) begin
        cfg_reg <= reg_wdata_in;
      end
      // option kept to 1 or 2
      if (reg_wr_in && reg_addr_in == cch_pkg::ADR_OPT) begin
        opt_reg <= (reg_wdata_in[1:0] == 2'h2) ? 2'h2 : 2'h1;
      end
    end
  end

  // trigger gated by mode and source
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trig_out <= 1'b0;
    end else begin
      trig_out <= cmd_vld && cmd == cch_pkg::CCH_CMD_TRG && bus_trig &&
                  (run_mode == cch_pkg::RUN_TRIG || run_mode == cch_pkg::RUN_BURST);
    end
  end

  // response sender: one byte per rsp_rd_in pulse, newline ends each answer
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rsp_active_reg <= 1'b0;
      rsp_rom_reg    <= 1'b0;
      rsp_addr_reg   <= '0;
      rsp_b0_reg     <= 8'h00;
      rsp_first_reg  <= 1'b0;
      opc_pend_reg   <= 1'b0;
      rsp_vld_out    <= 1'b0;
      rsp_byte_out   <= 8'h00;
    end else begin
      if (!rsp_active_reg && cmd_vld) begin
        rsp_addr_reg  <= '0;
        rsp_first_reg <= 1'b1;
        unique case (cmd)
          // answer after prior work is done
          cch_pkg::CCH_CMD_OPC: begin
            opc_pend_reg <= 1'b1;
          end
          cch_pkg::CCH_CMD_STB: begin
            rsp_active_reg <= 1'b1;
            rsp_b0_reg     <= stb_val;
          end
          cch_pkg::CCH_CMD_IDN: begin
            rsp_active_reg <= 1'b1;
            rsp_rom_reg    <= 1'b1;
          end
          cch_pkg::CCH_CMD_OPT: begin
            rsp_active_reg <= 1'b1;
            rsp_b0_reg     <= (opt_reg == 2'h2) ? cch_pkg::CH_TWO : cch_pkg::CH_ONE;
          end
          default: begin
            rsp_first_reg <= 1'b0;
          end
        endcase
      end else if (opc_pend_reg && !busy_in) begin
        opc_pend_reg   <= 1'b0;
        rsp_active_reg <= 1'b1;
        rsp_b0_reg     <= cch_pkg::CH_ONE;
      end
      rsp_vld_out <= rsp_active_reg;
      if (rsp_rom_reg) begin
        rsp_byte_out <= rom_data;
      end else begin
        rsp_byte_out <= rsp_first_reg ? rsp_b0_reg : cch_pkg::CH_NL;
      end
      if (rsp_active_reg && rsp_vld_out && rsp_rd_in) begin
        rsp_vld_out <= 1'b0;
        if (rsp_byte_out == cch_pkg::CH_NL) begin
          rsp_active_reg <= 1'b0;
          rsp_rom_reg    <= 1'b0;
        end
        rsp_first_reg <= 1'b0;
        rsp_addr_reg  <= rsp_addr_reg + 5'h01;
      end
    end
  end

  // hold off while an answer waits
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_off_out <= 1'b0;
      stb_out      <= 8'h00;
    end else begin
      hold_off_out <= opc_pend_reg || rsp_active_reg || cmd_vld;
      stb_out      <= stb_val;
    end
  end

  // error, trigger, reset and answer-start events visible to controller
  always_comb begin
    irq_ev = '0;
    irq_ev[cch_pkg::IRQ_ERR] = cmd_vld && cmd == cch_pkg::CCH_CMD_BAD;
    irq_ev[cch_pkg::IRQ_TRG] = trig_out;
    irq_ev[cch_pkg::IRQ_RST] = dflt_out;
    irq_ev[cch_pkg::IRQ_RSP] = rsp_active_reg && !rsp_vld_out && rsp_first_reg;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_st_reg <= '0;
      irq_en_reg <= '0;
      irq_out    <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == cch_pkg::ADR_IRQ_CL) begin
        irq_st_reg <= (irq_st_reg & ~reg_wdata_in[cch_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_st_reg <= irq_st_reg | irq_ev;
      end
      if (reg_wr_in && reg_addr_in == cch_pkg::ADR_IRQ_EN) begin
        irq_en_reg <= reg_wdata_in[cch_pkg::IRQ_W-1:0];
      end
      irq_out <= |(irq_st_reg & irq_en_reg);
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= 8'h00;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          cch_pkg::ADR_IRQ_ST: reg_rdata_out <= {4'h0, irq_st_reg};
          cch_pkg::ADR_IRQ_EN: reg_rdata_out <= {4'h0, irq_en_reg};
          cch_pkg::ADR_CFG:    reg_rdata_out <= cfg_reg;
          cch_pkg::ADR_STB:    reg_rdata_out <= stb_val;
          cch_pkg::ADR_ESR:    reg_rdata_out <= esr_reg;
          cch_pkg::ADR_OPT:    reg_rdata_out <= {6'h00, opt_reg};
          cch_pkg::ADR_ERRCNT: reg_rdata_out <= err_cnt_reg;
          default:             reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  property p_trig_gate;
    @(posedge mclk_in) disable iff (!rstn_in)
      trig_out |-> $past(bus_trig) &&
        ($past(run_mode) == cch_pkg::RUN_TRIG || $past(run_mode) == cch_pkg::RUN_BURST);
  endproperty
  a_trig_gate: assert property (p_trig_gate) else $error("trigger outside bus trig mode");

  property p_rst_cfg;
    @(posedge mclk_in) disable iff (!rstn_in)
      (cmd_vld && cmd == cch_pkg::CCH_CMD_RST && !reg_wr_in) |=> cfg_reg == cch_pkg::CFG_RESET;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("reset left settings");

  property p_cls;
    @(posedge mclk_in) disable iff (!rstn_in)
      (cmd_vld && cmd == cch_pkg::CCH_CMD_CLS) |=> esr_reg == 8'h00;
  endproperty
  a_cls: assert property (p_cls) else $error("clear status left events");

  property p_opc_wait;
    @(posedge mclk_in) disable iff (!rstn_in)
      (opc_pend_reg && busy_in) |=> opc_pend_reg;
  endproperty
  a_opc_wait: assert property (p_opc_wait) else $error("opc answered while busy");

  property p_hold;
    @(posedge mclk_in) disable iff (!rstn_in)
      opc_pend_reg |=> hold_off_out;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold off while opc pending");

  property p_rqs_keep;
    @(posedge mclk_in) disable iff (!rstn_in)
      (rqs_reg && !poll_in && !(cmd_vld && cmd == cch_pkg::CCH_CMD_CLS)) |=> rqs_reg;
  endproperty
  a_rqs_keep: assert property (p_rqs_keep) else $error("service bit lost");

  property p_opt_val;
    @(posedge mclk_in) disable iff (!rstn_in)
      opt_reg == 2'h1 || opt_reg == 2'h2;
  endproperty
  a_opt_val: assert property (p_opt_val) else $error("option out of range");

  property p_bad_quiet;
    @(posedge mclk_in) disable iff (!rstn_in)
      (cmd_vld && cmd == cch_pkg::CCH_CMD_BAD && !reg_wr_in) |=> $stable(cfg_reg) && !trig_out;
  endproperty
  a_bad_quiet: assert property (p_bad_quiet) else $error("bad command changed state");
endmodule : cch_top
